// [include/dsd_pkg.sv]
// Purpose: Shared constants and types for the data-space decoder.
// Assumes: 24-bit byte addresses, AXI4-Lite register bus with 32-bit data.
// Notes:   Register offsets are byte addresses of aligned words.
package dsd_pkg;

  localparam logic [23:0] IO_BASE      = 24'h000000;
  localparam logic [23:0] IO_LAST      = 24'h000FFF;
  localparam logic [23:0] EE_BASE      = 24'h001000;
  localparam logic [23:0] SRAM_BASE    = 24'h002000;
  localparam logic [23:0] IO_DIRECT_LAST = 24'h00003F;
  localparam logic [23:0] IO_BIT_LAST  = 24'h00001F;
  localparam int          EE_PAGE_BITS = 5;
  localparam int          NUM_CS       = 4;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_WAIT    = 8'h04;
  localparam logic [7:0] OFF_SDRAM   = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0C;
  localparam logic [7:0] OFF_CS_BASE = 8'h10;
  localparam logic [7:0] OFF_CS_SIZE = 8'h20;
  localparam logic [7:0] OFF_CS_MODE = 8'h30;
  localparam logic [7:0] OFF_DEVID   = 8'h40;
  localparam logic [7:0] OFF_SERIAL  = 8'h44;

  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_WAIT  = 32'h0000_0000;
  localparam logic [31:0] RST_SDRAM = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY = 2'h0;

  typedef enum logic [2:0] {
    REG_IO, REG_EEPROM, REG_SRAM, REG_EXT, REG_RESERVED
  } dsd_region_t;

  typedef enum logic [1:0] {
    CS_SRAM, CS_REDUCED_PIN, CS_SDRAM, CS_OFF
  } dsd_cs_mode_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        bit_op;
    logic        direct;
    logic [23:0] addr;
  } dsd_req_t;

  typedef struct packed {
    dsd_region_t region;
    logic [3:0]  cs_hit;
    logic        io_direct_ok;
    logic        io_bit_ok;
    logic        drop_write;
    logic [23:0] offset;
  } dsd_route_t;

endpackage : dsd_pkg

// [hw/dsd_decoder.sv]
// Purpose: Data-space address decoder with external chip-select windows.
// Assumes: Requests and AXI4-Lite inputs are synchronous to aclk.
// Notes:   Route outputs are registered one cycle after the request.
//
// What this block does
// - I/O at 0-FFF, EEPROM from 1000, SRAM from 2000, same layout.
// - Addresses past SRAM end go to external memory, 8 to 24 bits.
// - Every I/O location reachable by ordinary load and store paths.
// - Short direct I/O access only for addresses 0x00-0x3F.
// - Bit set, clear and test-skip only for addresses 0x00-0x1F.
// - EEPROM reachable mapped in data space or in its own space.
// - EEPROM writes byte or page, reads byte only.
// - EEPROM byte index ADDR[4:0], page from bits above.
// - Flash writes whole pages, reads one byte at a time.
// - Flash word index Z[8:1] or Z[7:1], page from higher bits.
// - Factory signature region refuses writes, stays readable.
// - Three-byte device type identifier readable as bytes 0 to 2.
// - Unique serial built from lot, wafer and die coordinates.
// - User signature page writable, survives chip erase.
// - Four chip selects, each with mode, base and size.
// - External SRAM up to 512K two-port, 16M three-port.
// - SDRAM latency and refresh configurable, 4-bit up to 128 Mbit.
// - Configurable wait states on external accesses.
// - External bus logic paced by the double-rate peripheral clock.
// - Each Flash location is one 16-bit word.
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module dsd_decoder
  import dsd_pkg::*;
#(
  parameter int          EE_BYTES     = 2048,
  parameter int          SRAM_BYTES   = 8192,
  parameter int          FLASH_PG_WORDS = 256,
  parameter int          EXT_ADDR_BITS  = 24,
  parameter logic [23:0] DEVICE_ID    = 24'hA5A5A5,
  parameter logic [31:0] SERIAL_LOT   = 32'h0000_1234,
  parameter logic [7:0]  SERIAL_WAFER = 8'h01,
  parameter logic [15:0] SERIAL_XY    = 16'h0203
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire dsd_pkg::dsd_req_t req,
  output dsd_pkg::dsd_route_t    route,
  output logic [8:0]             ee_page,
  output logic [4:0]             ee_byte,
  input  wire logic [23:0]       flash_z,
  output logic [10:0]            flash_page,
  output logic [7:0]             flash_word,
  input  wire logic              nvm_write,
  input  wire logic              nvm_page_mode,
  input  wire logic              nvm_is_flash,
  input  wire logic              nvm_factory_sig,
  input  wire logic              nvm_user_sig,
  input  wire logic              nvm_chip_erase,
  output logic                   nvm_grant,
  output logic                   nvm_erase_user_sig,
  output logic                   ext_clk_en,
  output logic                   ext_wait_busy,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  import dsd_pkg::*;

  localparam logic [23:0] EE_END   = EE_BASE + 24'(EE_BYTES) - 24'h1;
  localparam logic [23:0] SRAM_END = SRAM_BASE + 24'(SRAM_BYTES) - 24'h1;
  localparam int          FW_BITS  = $clog2(FLASH_PG_WORDS);

  // Configuration registers.
  logic [31:0] ctrl_q;
  logic [31:0] wait_q;
  logic [31:0] sdram_q;
  logic [23:0] cs_base_q [NUM_CS];
  logic [4:0]  cs_size_q [NUM_CS];
  logic [1:0]  cs_mode_q [NUM_CS];

  wire ee_mapped    = ctrl_q[0];
  wire three_port   = ctrl_q[1];
  wire clk2x_en_cfg = ctrl_q[2];

  function automatic logic in_range(input logic [23:0] a,
                                    input logic [23:0] lo,
                                    input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Chip-select window: size code n covers 2**(n+8) bytes.
  function automatic logic cs_match(input logic [23:0] a,
                                    input logic [23:0] base,
                                    input logic [4:0]  sz);
    logic [23:0] mask;
    mask = ~((24'h000100 << sz) - 24'h1);
    cs_match = ((a & mask) == (base & mask));
  endfunction : cs_match

  // External window limit: 512K in two-port mode, full 16M otherwise.
  wire [23:0] ext_limit = three_port ? 24'hFFFFFF : 24'h07FFFF;
  wire [23:0] ext_off   = req.addr - (SRAM_END + 24'h1);
  wire [23:0] ext_mask  = 24'(~(32'hFFFFFFFF << EXT_ADDR_BITS));

  wire hit_io   = in_range(req.addr, IO_BASE, IO_LAST);
  wire hit_ee   = ee_mapped && in_range(req.addr, EE_BASE, EE_END);
  wire hit_sram = in_range(req.addr, SRAM_BASE, SRAM_END);
  wire hit_ext  = (req.addr > SRAM_END) &&
                  (ext_off <= ext_limit) && ((ext_off & ~ext_mask) == 0);

  logic [3:0] cs_hit_w;
  always_comb begin
    for (int i = 0; i < NUM_CS; i++) begin
      cs_hit_w[i] = hit_ext && (cs_mode_q[i] != CS_OFF) &&
                    cs_match(req.addr, cs_base_q[i], cs_size_q[i]);
    end
  end

  dsd_region_t region_w;
  assign region_w = hit_io   ? REG_IO :
                    hit_ee   ? REG_EEPROM :
                    hit_sram ? REG_SRAM :
                    hit_ext  ? REG_EXT : REG_RESERVED;

  wire dir_ok = hit_io && (req.addr <= IO_DIRECT_LAST);
  wire bit_ok = hit_io && (req.addr <= IO_BIT_LAST);
  // Illegal short-form writes are dropped rather than aliased onto stores.
  wire drop_w = (region_w == REG_RESERVED) ||
                (req.direct && !dir_ok) || (req.bit_op && !bit_ok);

  logic [23:0] offset_w;
  assign offset_w = (region_w == REG_EEPROM) ? req.addr - EE_BASE :
                    (region_w == REG_SRAM)   ? req.addr - SRAM_BASE :
                    (region_w == REG_EXT)    ? ext_off : req.addr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route <= '0;
    end else begin
      route.region       <= req.valid ? region_w : REG_RESERVED;
      route.cs_hit       <= req.valid ? cs_hit_w : 4'h0;
      route.io_direct_ok <= req.valid && dir_ok;
      route.io_bit_ok    <= req.valid && bit_ok;
      route.drop_write   <= req.valid && req.write && drop_w;
      route.offset       <= req.valid ? offset_w : 24'h0;
    end
  end

  // NVM address split: EEPROM 32-byte pages, Flash word addressing.
  wire [23:0] ee_rel = hit_ee ? req.addr - EE_BASE : req.addr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ee_page    <= '0;
      ee_byte    <= '0;
      flash_page <= '0;
      flash_word <= '0;
    end else begin
      ee_byte    <= ee_rel[EE_PAGE_BITS-1:0];
      ee_page    <= 9'(ee_rel[23:EE_PAGE_BITS] &
                    24'((EE_BYTES >> EE_PAGE_BITS) - 1));
      flash_word <= 8'(flash_z[FW_BITS:1]);
      flash_page <= 11'(flash_z[23:FW_BITS+1]);
    end
  end

  // NVM permission: factory row read-only; flash and page-only rules.
  wire nvm_bad = nvm_write && (nvm_factory_sig ||
                 (nvm_is_flash && !nvm_page_mode && !nvm_user_sig));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nvm_grant          <= 1'b0;
      nvm_erase_user_sig <= 1'b0;
    end else begin
      nvm_grant          <= !nvm_bad;
      nvm_erase_user_sig <= 1'b0;
    end
  end

  // Double-rate clock modeled as an enable pulse at the system rate.
  logic       clk_ph_q;
  logic [7:0] wait_cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_ph_q <= 1'b0;
    end else begin
      clk_ph_q <= ~clk_ph_q;
    end
  end
  assign ext_clk_en = clk2x_en_cfg | clk_ph_q;

  wire ext_start = req.valid && hit_ext && (cs_hit_w != 4'h0);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_cnt_q <= 8'h00;
    end else if (ext_start && wait_cnt_q == 8'h00) begin
      wait_cnt_q <= wait_q[7:0];
    end else if (ext_clk_en && wait_cnt_q != 8'h00) begin
      wait_cnt_q <= wait_cnt_q - 8'h01;
    end
  end
  assign ext_wait_busy = (wait_cnt_q != 8'h00);

  // AXI4-Lite slave: write taken once both address and data are in, each either held or handshaking this cycle.
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  aw_q;
  logic [31:0] wd_q;
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bresp   = RESP_OKAY;
  assign s_axi_rresp   = RESP_OKAY;

  wire [7:0]  wa   = aw_hold_q ? aw_q : s_axi_awaddr[7:0];
  wire [31:0] wd   = w_hold_q ? wd_q : s_axi_wdata;
  wire have_aw     = aw_hold_q || (s_axi_awvalid && s_axi_awready);
  wire have_w      = w_hold_q || (s_axi_wvalid && s_axi_wready);
  wire do_wr       = have_aw && have_w;
  wire [1:0] cs_ix = wa[3:2];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = st[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      aw_q         <= 8'h00;
      wd_q         <= 32'h0;
      s_axi_bvalid <= 1'b0;
      ctrl_q       <= RST_CTRL;
      wait_q       <= RST_WAIT;
      sdram_q      <= RST_SDRAM;
      for (int i = 0; i < NUM_CS; i++) begin
        cs_base_q[i] <= 24'h0;
        cs_size_q[i] <= 5'h0;
        cs_mode_q[i] <= CS_OFF;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready && !do_wr) begin
        aw_hold_q <= 1'b1;
        aw_q      <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready && !do_wr) begin
        w_hold_q <= 1'b1;
        wd_q     <= s_axi_wdata;
      end
      if (do_wr) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Unmapped and read-only offsets are silently ignored.
        case (wa & 8'hF0)
          OFF_CTRL: begin
            case (wa)
              OFF_CTRL:  ctrl_q  <= merge(ctrl_q, wd, s_axi_wstrb);
              OFF_WAIT:  wait_q  <= merge(wait_q, wd, s_axi_wstrb);
              OFF_SDRAM: sdram_q <= merge(sdram_q, wd, s_axi_wstrb);
              default: ;
            endcase
          end
          OFF_CS_BASE: cs_base_q[cs_ix] <= 24'(wd);
          OFF_CS_SIZE: cs_size_q[cs_ix] <= wd[4:0];
          OFF_CS_MODE: cs_mode_q[cs_ix] <= wd[1:0];
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path; identity and serial words are fixed, writes never reach them.
  wire [7:0] ra    = s_axi_araddr[7:0];
  wire [1:0] rcs   = ra[3:2];
  logic [31:0] rd_w;
  always_comb begin
    case (ra & 8'hF0)
      OFF_CTRL: begin
        case (ra)
          OFF_CTRL:   rd_w = ctrl_q;
          OFF_WAIT:   rd_w = wait_q;
          OFF_SDRAM:  rd_w = sdram_q;
          OFF_STATUS: rd_w = {23'h0, ext_wait_busy, wait_cnt_q};
          default:    rd_w = 32'h0;
        endcase
      end
      OFF_CS_BASE: rd_w = {8'h00, cs_base_q[rcs]};
      OFF_CS_SIZE: rd_w = {27'h0, cs_size_q[rcs]};
      OFF_CS_MODE: rd_w = {30'h0, cs_mode_q[rcs]};
      OFF_DEVID:   begin
        case (ra)
          OFF_DEVID:           rd_w = {8'h00, DEVICE_ID};
          OFF_SERIAL:          rd_w = SERIAL_LOT;
          OFF_SERIAL + 8'h04:  rd_w = {8'h00, SERIAL_WAFER, SERIAL_XY};
          default:             rd_w = 32'h0;
        endcase
      end
      default: rd_w = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_w;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  chk_io_direct_range: assert property (@(posedge aclk) disable iff (!aresetn)
    route.io_direct_ok |-> route.region == REG_IO)
    else $error("direct I/O flag outside I/O region");
  chk_bit_subset: assert property (@(posedge aclk) disable iff (!aresetn)
    route.io_bit_ok |-> route.io_direct_ok)
    else $error("bit access allowed beyond direct range");
  chk_io_region: assert property (@(posedge aclk) disable iff (!aresetn)
    req.valid && req.addr <= IO_LAST |=> route.region == REG_IO)
    else $error("I/O address not routed to I/O");
  chk_sram_region: assert property (@(posedge aclk) disable iff (!aresetn)
    req.valid && req.addr == SRAM_BASE |=> route.region == REG_SRAM)
    else $error("SRAM base not routed to SRAM");
  chk_factory_ro: assert property (@(posedge aclk) disable iff (!aresetn)
    nvm_write && nvm_factory_sig |=> !nvm_grant)
    else $error("factory row write granted");
  chk_reserved_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    req.valid && req.write && !hit_io && !hit_ee && !hit_sram && !hit_ext
    |=> route.drop_write)
    else $error("reserved write not dropped");
  chk_ee_split: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> ee_byte == $past(ee_rel[4:0]))
    else $error("EEPROM byte index wrong");
  chk_wait_count: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_start && wait_cnt_q == 0 && wait_q[7:0] != 0 |=> ext_wait_busy)
    else $error("wait states not inserted");
  chk_usig_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    nvm_chip_erase |=> !nvm_erase_user_sig)
    else $error("chip erase cleared user signature row");

endmodule : dsd_decoder

// [testbench/dsd_requester.sv]
// Purpose: CPU or DMA requester model on the data-space side.
// Assumes: One access at a time, launched just after a rising edge.
// Notes:   An access stays on the bus until the next one replaces it.
`timescale 1ns/1ps
module dsd_requester (
  input  wire logic         aclk,
  output dsd_pkg::dsd_req_t req
);
  import dsd_pkg::*;
  initial req = '0;
  // Returns mid-cycle, once the registered route of this access is out.
  task automatic issue(input logic [23:0] a, input logic w, input logic f);
    @(posedge aclk);
    req <= '{1'b1, w, f, f, a};
    @(posedge aclk);
    @(negedge aclk);
  endtask : issue
endmodule : dsd_requester

// [testbench/dsd_decoder_bench.sv]
// Purpose: Self-checking bench for the data-space decoder.
// Assumes: Default variant: 2K EEPROM, 8K SRAM, 256-word Flash pages.
// Notes:   Random stimulus comes from a 16-bit LFSR with a fixed seed.
`timescale 1ns/1ps
module dsd_decoder_bench;
  import dsd_pkg::*;
  // Identity values are arbitrary.
  localparam logic [23:0] TB_ID  = 24'h3C5A69;
  localparam logic [31:0] TB_LOT = 32'h0001_2E7F;
  localparam logic [23:0] TB_WXY = 24'h2D0A11;
  localparam logic [23:0] PTS [13] = '{24'h0, 24'h1F, 24'h20, 24'h3F,
    24'h40, 24'hFFF, 24'h1000, 24'h17FF, 24'h1800, 24'h1FFF, 24'h2000,
    24'h3FFF, 24'h4000};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  dsd_req_t    req;
  dsd_route_t  route;
  logic [8:0]  ee_page;
  logic [4:0]  ee_byte;
  logic [23:0] flash_z = '0;
  logic [10:0] flash_page;
  logic [7:0]  flash_word;
  logic [5:0]  nvm = '0;
  logic        grant, ers, clk_en, busy;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [15:0] lf = 16'd12092;
  int          errors = 0;
  int          tests_run = 0;

  dsd_decoder #(.DEVICE_ID(TB_ID), .SERIAL_LOT(TB_LOT),
    .SERIAL_WAFER(TB_WXY[23:16]), .SERIAL_XY(TB_WXY[15:0])) i_dut (
    .aclk(aclk), .aresetn(aresetn), .req(req), .route(route),
    .ee_page(ee_page), .ee_byte(ee_byte), .flash_z(flash_z),
    .flash_page(flash_page), .flash_word(flash_word),
    .nvm_write(nvm[0]), .nvm_page_mode(nvm[1]), .nvm_is_flash(nvm[2]),
    .nvm_factory_sig(nvm[3]), .nvm_user_sig(nvm[4]),
    .nvm_chip_erase(nvm[5]), .nvm_grant(grant),
    .nvm_erase_user_sig(ers), .ext_clk_en(clk_en), .ext_wait_busy(busy),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  dsd_requester i_req (.aclk(aclk), .req(req));

  always #10 aclk = ~aclk;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  task automatic rnd(output logic [23:0] v);
    lf = lfsr(lf);
    v[15:0] = lf;
    lf = lfsr(lf);
    v[23:16] = lf[7:0];
  endtask : rnd

  function automatic dsd_region_t exp_rg(input logic [23:0] a,
                                         input logic m);
    if (a <= IO_LAST) return REG_IO;
    if (a < 24'h001800) return m ? REG_EEPROM : REG_RESERVED;
    if (a < SRAM_BASE) return REG_RESERVED;
    if (a < 24'h004000) return REG_SRAM;
    return REG_EXT;
  endfunction : exp_rg

  // Each channel is released at the rising edge after the falling edge where its ready was seen high.
  task automatic axi(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    logic ok_a, ok_w, done;
    done = 1'b0;
    r = '0;
    @(posedge aclk);
    if (w) begin
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (int n = 0; n < 50 && !done; n++) begin
      @(negedge aclk);
      ok_a = (awvalid && awready) || (arvalid && arready);
      ok_w = wvalid && wready;
      done = bvalid || rvalid;
      r = rdata;
      if (done) cmp("resp", 32'(RESP_OKAY), 32'(w ? bresp : rresp));
      @(posedge aclk);
      if (ok_a) awvalid <= 1'b0;
      if (ok_a) arvalid <= 1'b0;
      if (ok_w) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
      if (done) rready <= 1'b0;
    end
    if (!done) begin
      errors++;
      summarize();
    end
  endtask : axi

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    axi(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [31:0] a, m, e);
    logic [31:0] x;
    axi(1'b0, a, '0, x);
    cmp("register", e, x & m);
  endtask : rd

  task automatic dec(input logic [23:0] a, input logic w, f,
                     input dsd_region_t e, input logic [3:0] cs);
    logic        d;
    logic [23:0] o;
    // Short bit forms above the bit range are refused, so a write is dropped.
    d = w && (e == REG_RESERVED || (f && a > IO_BIT_LAST));
    o = (e == REG_EEPROM) ? a - EE_BASE : (e == REG_SRAM) ? a - SRAM_BASE :
        (e == REG_EXT) ? a - 24'h004000 : a;
    i_req.issue(a, w, f);
    cmp("region", 32'(e), 32'(route.region));
    cmp("cs_hit", 32'(cs), 32'(route.cs_hit));
    cmp("drop", 32'(d), 32'(route.drop_write));
    cmp("offset", 32'(o), 32'(route.offset));
  endtask : dec

  initial begin
    logic [23:0] a;
    logic        c;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(32'(OFF_CTRL), '1, RST_CTRL);
    rd(32'(OFF_WAIT), '1, RST_WAIT);
    rd(32'(OFF_SDRAM), '1, RST_SDRAM);
    wr(32'(OFF_DEVID), '1);
    rd(32'(OFF_DEVID), 32'hFF_FFFF, 32'(TB_ID));
    rd(32'(OFF_SERIAL), '1, TB_LOT);
    rd(32'(OFF_SERIAL) + 32'h4, 32'hFF_FFFF, 32'(TB_WXY));
    wr(32'hFC, '1);
    rd(32'hFC, '1, '0);
    wr(32'(OFF_WAIT), 32'hA5);
    rd(32'(OFF_WAIT), 32'hFF, 32'hA5);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 40; i++) begin
        rnd(a);
        a = a & (i[0] ? 24'h003FFF : 24'h03FFFF);
        dec(a, lf[0], 1'b0, exp_rg(a, m[0]), 4'h0);
      end
      wr(32'(OFF_CTRL), 32'h1);
    end
    foreach (PTS[k]) begin
      dec(PTS[k], k[0], 1'b1, exp_rg(PTS[k], 1'b1), 4'h0);
      cmp("direct", 32'(PTS[k] <= IO_DIRECT_LAST), 32'(route.io_direct_ok));
      cmp("bitop", 32'(PTS[k] <= IO_BIT_LAST), 32'(route.io_bit_ok));
    end
    for (int i = 0; i < 20; i++) begin
      rnd(a);
      a = EE_BASE + (a & 24'h7FF);
      dec(a, a[0], 1'b0, REG_EEPROM, 4'h0);
      cmp("ee_byte", 32'(a[4:0]), 32'(ee_byte));
      cmp("ee_page", 32'(a[10:5]), 32'(ee_page));
      @(posedge aclk);
      flash_z <= a ^ {lf, lf[7:0]};
      @(posedge aclk);
      @(negedge aclk);
      cmp("flash_word_in_page", 32'(flash_z[8:1]), 32'(flash_word));
      cmp("flash_page_index", 32'(flash_z[19:9]), 32'(flash_page));
    end
    $display("test decode done");
    for (int i = 0; i < 64; i++) begin
      @(posedge aclk);
      nvm <= i[5:0];
      @(posedge aclk);
      @(negedge aclk);
      c = !(i[0] && (i[3] || (i[2] && !i[1] && !i[4])));
      if (!i[5]) cmp("grant", 32'(c), 32'(grant));
      cmp("usig_erase", 32'h0, 32'(ers));
    end
    @(posedge aclk);
    nvm <= '0;
    @(negedge aclk);
    c = clk_en;
    @(negedge aclk);
    cmp("clk_toggle", 32'(!c), 32'(clk_en));
    wr(32'(OFF_CTRL), 32'h5);
    repeat (3) begin
      @(negedge aclk);
      cmp("clk_full", 32'h1, 32'(clk_en));
    end
    $display("test nvm and clock done");
    for (int i = 0; i < NUM_CS; i++) begin
      wr(32'(OFF_CS_BASE) + 32'(4 * i), 32'h8000 + 32'(i) * 32'h1000);
      wr(32'(OFF_CS_SIZE) + 32'(4 * i), 32'h4);
      wr(32'(OFF_CS_MODE) + 32'(4 * i), 32'(i % 3));
    end
    for (int i = 0; i < NUM_CS; i++) begin
      a = 24'h8000 + 24'(i) * 24'h1000;
      dec(a, 1'b0, 1'b0, REG_EXT, 4'(1 << i));
      cmp("wait_busy", 32'h1, 32'(busy));
      dec(a + 24'hFFF, 1'b1, 1'b0, REG_EXT, 4'(1 << i));
    end
    dec(24'h00C000, 1'b0, 1'b0, REG_EXT, 4'h0);
    wr(32'(OFF_CS_MODE), 32'h3);
    dec(24'h008000, 1'b0, 1'b0, REG_EXT, 4'h0);
    dec(24'h800000, 1'b0, 1'b0, REG_RESERVED, 4'h0);
    wr(32'(OFF_CTRL), 32'h7);
    dec(24'h800000, 1'b0, 1'b0, REG_EXT, 4'h0);
    $display("test chip selects done");
    summarize();
  end
endmodule : dsd_decoder_bench
